// [hdl/qse_status_echo.sv]
/*
 questionable status registers, summary bit, tone trigger and serial echo.
 assumes commands arrive as one-cycle strobes from a command parser that
 has already decoded the remote strings; serial characters arrive as
 one-cycle strobes and leave over a valid/ready port.
*/
// What this block does
// - the latched event register is read-only and a read returns it whole then clears it.
// - only current error (bit 13) and voltage error (bit 12) ever latch into the events.
// - current mode (bit 1) and voltage mode (bit 0) are never latched, only shown live.
// - current error is bit 13, voltage error bit 12, current mode bit 1, voltage mode bit 0.
// - the live condition register shows each condition as 1 while active, 0 otherwise.
// - both mode bits may read as set together while the supply settles.
// - the mask register selects per bit which conditions may set the event bits.
// - the summary flag sits at bit 3 of the status byte, fed from masked events.
// - the summary flag is the OR of every position with both event and mask set.
// - a mask write loads an integer and a mask query returns it unchanged.
// - the tone command gives a short pulse on the tone output.
// - with echo on, each received character is sent back unless it finds the two-entry buffer full.
// - after echo off, echo continues up to and including the next line terminator.
// - instrument reset leaves the echo setting alone.
// - the echo query answers on while echo is active, including after echo off until the next line terminator, and off after that.
// - the preset command clears the condition register for one cycle; latched events are kept and still reported.
`timescale 1ns/1ps
`default_nettype none
module qse_status_echo
    import qse_pkg::*;
#(
    parameter int unsigned TONE_CYCLES = qse_pkg::QSE_TONE_CYCLES
) (
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_i,
    // supply condition inputs
    input  wire logic                          current_error_i,
    input  wire logic                          voltage_error_i,
    input  wire logic                          current_mode_flag_i,
    input  wire logic                          voltage_mode_flag_i,
    // decoded command strobe
    input  wire qse_pkg::qse_cmd_e             cmd_i,
    input  wire logic [qse_pkg::QSE_WIDTH-1:0] cmd_data_i,
    input  wire logic                          instrument_reset_i,
    input  wire logic                          echo_set_i,
    input  wire logic                          echo_on_i,
    // command reply
    output logic                               reply_valid_o,
    output logic [qse_pkg::QSE_WIDTH-1:0]      reply_data_o,
    output logic                               echo_state_o,
    // status byte contribution
    output logic                               summary_o,
    // tone
    output logic                               tone_o,
    // serial characters
    input  wire logic                          rx_valid_i,
    input  wire logic [7:0]                    rx_data_i,
    output logic                               tx_valid_o,
    output logic [7:0]                         tx_data_o,
    input  wire logic                          tx_ready_i,
    output logic                               rx_drop_o
);
    import qse_pkg::*;

    // ========================================================
    // live conditions
    logic [QSE_WIDTH-1:0] raw_cond;
    logic [QSE_WIDTH-1:0] cond_reg;
    logic [QSE_WIDTH-1:0] event_reg;
    logic [QSE_WIDTH-1:0] mask_reg;
    logic                 preset_hold_reg;
    logic                 read_evt;

    always_comb begin
        raw_cond = '0;
        raw_cond[QSE_BIT_CURR_ERR]  = current_error_i;
        raw_cond[QSE_BIT_VOLT_ERR]  = voltage_error_i;
        raw_cond[QSE_BIT_CURR_MODE] = current_mode_flag_i;
        raw_cond[QSE_BIT_VOLT_MODE] = voltage_mode_flag_i;
    end

    // both mode bits pass through independently, so settling shows as 3
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cond_reg <= '0;
        end else if (cmd_i == QSE_CMD_PRESET) begin
            cond_reg <= '0;
        end else begin
            cond_reg <= raw_cond & QSE_LIVE_MASK;
        end
    end

    // preset also blocks the event capture in the cycle after its own
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            preset_hold_reg <= 1'b0;
        end else begin
            preset_hold_reg <= (cmd_i == QSE_CMD_PRESET);
        end
    end

    // ========================================================
    // latched events
    assign read_evt = (cmd_i == QSE_CMD_READ_EVT);

    // set wins over the read-clear so an event in the read cycle survives
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            event_reg <= '0;
        end else begin
            event_reg <= (read_evt ? '0 : event_reg)
                       | (preset_hold_reg ? '0
                          : (cond_reg & mask_reg & QSE_LATCH_MASK));
        end
    end

    // ========================================================
    // mask register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mask_reg <= QSE_MASK_RESET;
        end else if (cmd_i == QSE_CMD_WRITE_MASK) begin
            mask_reg <= cmd_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            summary_o <= 1'b0;
        end else begin
            summary_o <= |(event_reg & mask_reg);
        end
    end

    // ========================================================
    // query replies
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            reply_valid_o <= 1'b0;
            reply_data_o  <= '0;
        end else begin
            reply_valid_o <= 1'b1;
            case (cmd_i)
                QSE_CMD_READ_EVT:  reply_data_o <= event_reg;
                QSE_CMD_READ_COND: reply_data_o <= cond_reg;
                QSE_CMD_READ_MASK: reply_data_o <= mask_reg;
                QSE_CMD_READ_ECHO: reply_data_o <= {{(QSE_WIDTH-1){1'b0}}, echo_state_o};
                default: begin
                    reply_valid_o <= 1'b0;
                    reply_data_o  <= reply_data_o;
                end
            endcase
        end
    end

    // ========================================================
    // tone
    qse_tone_gen #(
        .CYCLES (TONE_CYCLES)
    ) u_tone (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .trigger_i  (cmd_i == QSE_CMD_TONE),
        .tone_o     (tone_o)
    );

    // ========================================================
    // serial echo
    logic echo_req_reg;
    logic echoing;

    // instrument reset is deliberately not a term here
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            echo_req_reg <= 1'b0;
        end else if (echo_set_i) begin
            echo_req_reg <= echo_on_i;
        end
    end

    // echo stays active after off until a terminator passes
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            echo_state_o <= 1'b0;
        end else if (echo_set_i && echo_on_i) begin
            echo_state_o <= 1'b1;
        end else if (!echo_req_reg && !(echo_set_i && echo_on_i)
                     && rx_valid_i && rx_data_i == QSE_LINE_TERM) begin
            echo_state_o <= 1'b0;
        end else if (instrument_reset_i) begin
            echo_state_o <= echo_state_o;
        end
    end

    assign echoing = echo_state_o || (echo_set_i && echo_on_i);

    qse_char_if #(.W(QSE_CHAR_WIDTH)) in_ch ();
    qse_char_if #(.W(QSE_CHAR_WIDTH)) out_ch ();

    assign in_ch.valid  = rx_valid_i && echoing;
    assign in_ch.data   = rx_data_i;

    qse_skid_buf #(
        .W     (QSE_CHAR_WIDTH),
        .DEPTH (2)
    ) u_buf (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .in_ch      (in_ch),
        .out_ch     (out_ch)
    );

    // registered output stage; takes a new word when empty or being taken
    assign out_ch.ready = !tx_valid_o || tx_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o  <= '0;
        end else if (out_ch.ready) begin
            tx_valid_o <= out_ch.valid;
            tx_data_o  <= out_ch.data;
        end
    end

    // a character that finds the buffer full cannot be held upstream
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rx_drop_o <= 1'b0;
        end else begin
            rx_drop_o <= in_ch.valid && !in_ch.ready;
        end
    end
endmodule : qse_status_echo
`default_nettype wire

// [hdl/qse_pkg.sv]
/*
 questionable status and echo block: shared constants and types.
 assumes a single 100 MHz clock domain.
*/
package qse_pkg;
    // ========================================================
    // questionable register layout
    localparam int unsigned QSE_WIDTH          = 16;
    localparam int unsigned QSE_BIT_CURR_ERR   = 13;
    localparam int unsigned QSE_BIT_VOLT_ERR   = 12;
    localparam int unsigned QSE_BIT_CURR_MODE  = 1;
    localparam int unsigned QSE_BIT_VOLT_MODE  = 0;
    localparam logic [15:0] QSE_LATCH_MASK     = 16'h3000;
    localparam logic [15:0] QSE_LIVE_MASK      = 16'h3003;
    localparam logic [15:0] QSE_MASK_RESET     = 16'h0000;
    localparam int unsigned QSE_STB_SUMMARY    = 3;
    // ========================================================
    // commands from the remote command parser
    typedef enum logic [2:0] {
        QSE_CMD_NONE       = 3'h0,
        QSE_CMD_READ_EVT   = 3'h1,
        QSE_CMD_READ_COND  = 3'h2,
        QSE_CMD_WRITE_MASK = 3'h3,
        QSE_CMD_READ_MASK  = 3'h4,
        QSE_CMD_PRESET     = 3'h5,
        QSE_CMD_TONE       = 3'h6,
        QSE_CMD_READ_ECHO  = 3'h7
    } qse_cmd_e;
    // ========================================================
    // timing and characters
    localparam int unsigned QSE_CLK_MHZ        = 100;
    localparam int unsigned QSE_TONE_US        = 100;
    localparam int unsigned QSE_TONE_CYCLES    = QSE_TONE_US * QSE_CLK_MHZ;
    localparam logic [7:0]  QSE_LINE_TERM      = 8'h0A;
    localparam int unsigned QSE_CHAR_WIDTH     = 8;
endpackage : qse_pkg

// [hdl/qse_char_if.sv]
/*
 valid/ready character channel between echo logic and its buffer.
 assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface qse_char_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : qse_char_if
`default_nettype wire

// [hdl/qse_skid_buf.sv]
/*
 two-entry buffer on the echo character path.
 assumes synchronous active-high reset; out side may stall.
*/
`timescale 1ns/1ps
`default_nettype none
module qse_skid_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // channels
    qse_char_if.dst   in_ch,
    qse_char_if.src   out_ch
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ch.ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_ch.valid = (cnt_reg != '0);
    assign out_ch.data  = mem_reg[rd_ptr_reg];
    assign push = in_ch.valid && in_ch.ready;
    assign pop  = out_ch.valid && out_ch.ready;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_ch.data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            case ({push, pop})
                2'b10:   cnt_reg <= cnt_reg + 1'b1;
                2'b01:   cnt_reg <= cnt_reg - 1'b1;
                default: cnt_reg <= cnt_reg;
            endcase
        end
    end
endmodule : qse_skid_buf
`default_nettype wire

// [hdl/qse_tone_gen.sv]
/*
 one-shot tone pulse generator.
 assumes a one-cycle trigger; a retrigger restarts the pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module qse_tone_gen #(
    parameter int unsigned CYCLES = 10000
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    // control
    input  wire logic trigger_i,
    output var  logic tone_o
);
    logic [$clog2(CYCLES+1)-1:0] left_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            left_reg <= '0;
            tone_o   <= 1'b0;
        end else if (trigger_i) begin
            left_reg <= ($clog2(CYCLES+1))'(CYCLES - 1);
            tone_o   <= 1'b1;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - 1'b1;
        end else begin
            tone_o <= 1'b0;
        end
    end
endmodule : qse_tone_gen
`default_nettype wire

// [tb/qse_status_echo_sva.sv]
/*
 checker for qse_status_echo: replies, condition, tone and echo timing.
 assumes a bind to the top module; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module qse_status_echo_sva
    import qse_pkg::*;
#(
    parameter int unsigned TONE_CYCLES = 8
) (
    input wire logic              core_clk_i,
    input wire logic              reset_i,
    input wire logic              current_error_i,
    input wire logic              voltage_error_i,
    input wire logic              current_mode_flag_i,
    input wire logic              voltage_mode_flag_i,
    input wire qse_pkg::qse_cmd_e cmd_i,
    input wire logic [15:0]       cmd_data_i,
    input wire logic              echo_set_i,
    input wire logic              echo_on_i,
    input wire logic              reply_valid_o,
    input wire logic [15:0]       reply_data_o,
    input wire logic              echo_state_o,
    input wire logic              tone_o,
    input wire logic              rx_valid_i,
    input wire logic [7:0]        rx_data_i,
    input wire logic              tx_valid_o,
    input wire logic [7:0]        tx_data_o,
    input wire logic              tx_ready_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic [15:0] tone_cnt;
    // ========================================================
    // tone length counter, restarted by each trigger
    always_ff @(posedge core_clk_i) begin
        if (reset_i || cmd_i == QSE_CMD_TONE) tone_cnt <= 16'h0000;
        else if (tone_o) tone_cnt <= tone_cnt + 16'h0001;
    end
    sequence s_mask_wr_rd;
        cmd_i == QSE_CMD_WRITE_MASK ##1 cmd_i == QSE_CMD_READ_MASK;
    endsequence
    // ========================================================
    // assertions
    chk_reply_now: assert property (cmd_i inside {QSE_CMD_READ_EVT, QSE_CMD_READ_COND,
        QSE_CMD_READ_MASK, QSE_CMD_READ_ECHO} |=> reply_valid_o) else $error("no reply");
    chk_mask_back: assert property (s_mask_wr_rd |=> reply_data_o == $past(cmd_data_i, 2))
        else $error("mask readback");
    chk_evt_bits: assert property (cmd_i == QSE_CMD_READ_EVT
        |=> (reply_data_o & ~QSE_LATCH_MASK) == 16'h0000) else $error("event bits");
    chk_cond_live: assert property (cmd_i == QSE_CMD_READ_COND
        && $past(cmd_i) != QSE_CMD_PRESET && !$past(reset_i)
        |=> reply_data_o == {2'b00, $past(current_error_i, 2), $past(voltage_error_i, 2),
        10'h000, $past(current_mode_flag_i, 2), $past(voltage_mode_flag_i, 2)})
        else $error("condition value");
    chk_tone_start: assert property (cmd_i == QSE_CMD_TONE |=> tone_o) else $error("tone");
    chk_tone_len: assert property ($fell(tone_o) |-> tone_cnt == TONE_CYCLES[15:0])
        else $error("tone length");
    chk_echo_on: assert property (echo_set_i && echo_on_i |=> echo_state_o)
        else $error("echo on");
    chk_echo_hold: assert property (echo_state_o
        && !(rx_valid_i && rx_data_i == QSE_LINE_TERM) |=> echo_state_o) else $error("echo off");
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_data_o)) else $error("tx dropped");
endmodule : qse_status_echo_sva
bind qse_status_echo qse_status_echo_sva #(.TONE_CYCLES(TONE_CYCLES)) u_sva (.*);
`default_nettype wire

// [tb/qse_host_model.sv]
/*
 remote side of the echo path: takes characters, may stall.
 assumes stall_i comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module qse_host_model (
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic       tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic       stall_i,
    output var logic       tx_ready_o
);
    logic [7:0] got[$];
    initial tx_ready_o = 1'b0;
    // ready moves on the rising edge by nba, so a stall set at a falling edge never races it
    always @(posedge core_clk_i) tx_ready_o <= !stall_i && !reset_i;
    always @(posedge core_clk_i) begin
        if (!reset_i && tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    end
endmodule : qse_host_model
`default_nettype wire

// [tb/qse_status_echo_tb.sv]
/*
 self-checking bench for qse_status_echo, random plus corner cases.
 assumes qse_host_model as the character sink.
*/
`timescale 1ns/1ps
`default_nettype none
module qse_status_echo_tb;
    import qse_pkg::*;
    logic core_clk_i, reset_i, current_error_i, voltage_error_i, current_mode_flag_i;
    logic voltage_mode_flag_i, instrument_reset_i, echo_set_i, echo_on_i, rx_valid_i;
    logic tx_ready_i, stall, reply_valid_o, echo_state_o, summary_o, tone_o, tx_valid_o;
    logic rx_drop_o;
    qse_cmd_e cmd_i;
    logic [15:0] cmd_data_i, reply_data_o;
    logic [7:0] rx_data_i, tx_data_o, exp_q[$];
    logic [31:0] seed;
    int bad_count, n_compared, drops, i, n;
    qse_status_echo #(.TONE_CYCLES(8)) u_qse_status_echo (.*);
    qse_host_model u_qse_host_model (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .stall_i(stall), .tx_ready_o(tx_ready_i));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) if (rx_drop_o === 1'b1) drops++;
    // ========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic put(input qse_cmd_e c, input logic [15:0] d);
        @(negedge core_clk_i);
        cmd_i = c;
        cmd_data_i = d;
    endtask : put
    task automatic cmd_go(input qse_cmd_e c, input logic [15:0] d);
        put(c, d);
        @(negedge core_clk_i);
        cmd_i = QSE_CMD_NONE;
    endtask : cmd_go
    task automatic read_chk(input qse_cmd_e c, input logic [15:0] e);
        cmd_go(c, 16'h0000);
        check(reply_valid_o === 1'b1 && reply_data_o === e, "reply");
    endtask : read_chk
    task automatic set_cond(input logic [3:0] v);
        @(negedge core_clk_i);
        {current_error_i, voltage_error_i, current_mode_flag_i, voltage_mode_flag_i} = v;
    endtask : set_cond
    task automatic send(input logic [7:0] c, input logic keep);
        @(negedge core_clk_i);
        rx_valid_i = 1'b1;
        rx_data_i = c;
        if (keep) exp_q.push_back(c);
        @(negedge core_clk_i);
        rx_valid_i = 1'b0;
    endtask : send
    task automatic echo(input logic on);
        @(negedge core_clk_i);
        echo_set_i = 1'b1;
        echo_on_i = on;
        @(negedge core_clk_i);
        echo_set_i = 1'b0;
    endtask : echo
    task automatic drain();
        n = 0;
        while (u_qse_host_model.got.size() < exp_q.size() && n < 200) begin
            @(negedge core_clk_i);
            n++;
        end
        repeat (6) @(negedge core_clk_i);
        check(u_qse_host_model.got == exp_q, "echo stream");
        u_qse_host_model.got.delete();
        exp_q.delete();
    endtask : drain
    task automatic print_verdict();
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // ========================================================
    // main sequence
    initial begin
        {instrument_reset_i, echo_set_i, echo_on_i, rx_valid_i, stall} = 5'h00;
        {current_error_i, voltage_error_i, current_mode_flag_i, voltage_mode_flag_i} = 4'h0;
        cmd_i = QSE_CMD_NONE;
        cmd_data_i = 16'h0000;
        rx_data_i = 8'h00;
        seed = 32'h33C8;
        reset_i = 1'b1;
        repeat (3) @(negedge core_clk_i);
        reset_i = 1'b0;
        check(reply_valid_o === 1'b0 && tone_o === 1'b0 && summary_o === 1'b0, "reset");
        read_chk(QSE_CMD_READ_MASK, QSE_MASK_RESET);
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            put(QSE_CMD_WRITE_MASK, i == 0 ? 16'hFFFF : seed[15:0]);
            read_chk(QSE_CMD_READ_MASK, cmd_data_i);
            set_cond(seed[19:16] | {2'b00, {2{i == 1}}});
            @(negedge core_clk_i);
            read_chk(QSE_CMD_READ_COND, {2'b00, seed[19:18], 10'h000, seed[17:16] | {2{i == 1}}});
        end
        set_cond(4'hF);
        put(QSE_CMD_PRESET, 16'h0000);
        read_chk(QSE_CMD_READ_COND, 16'h0000);
        set_cond(4'h0);
        repeat (3) @(negedge core_clk_i);
        cmd_go(QSE_CMD_READ_EVT, 16'h0000);
        cmd_go(QSE_CMD_WRITE_MASK, 16'h3003);
        set_cond(4'hB);
        set_cond(4'h0);
        repeat (3) @(negedge core_clk_i);
        check(summary_o === 1'b1, "summary set");
        read_chk(QSE_CMD_READ_EVT, 16'h2000);
        read_chk(QSE_CMD_READ_EVT, 16'h0000);
        check(summary_o === 1'b0, "summary clear");
        cmd_go(QSE_CMD_WRITE_MASK, 16'h1000);
        set_cond(4'hC);
        set_cond(4'h0);
        repeat (3) @(negedge core_clk_i);
        check(summary_o === 1'b1, "summary masked");
        read_chk(QSE_CMD_READ_EVT, 16'h1000);
        cmd_go(QSE_CMD_TONE, 16'h0000);
        n = 0;
        while (tone_o === 1'b1 && n < 20) begin
            n++;
            @(negedge core_clk_i);
        end
        check(n == 8, "tone length");
        read_chk(QSE_CMD_READ_ECHO, 16'h0000);
        echo(1'b1);
        instrument_reset_i = 1'b1;
        @(negedge core_clk_i);
        instrument_reset_i = 1'b0;
        read_chk(QSE_CMD_READ_ECHO, 16'h0001);
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            // stall only every other char so the two-entry buffer never overflows here
            stall = seed[8] && i[0];
            send(seed[7:0] | 8'h80, 1'b1);
        end
        stall = 1'b0;
        drain();
        echo(1'b0);
        read_chk(QSE_CMD_READ_ECHO, 16'h0001);
        send(8'h41, 1'b1);
        send(QSE_LINE_TERM, 1'b1);
        send(8'h42, 1'b0);
        read_chk(QSE_CMD_READ_ECHO, 16'h0000);
        drain();
        // stalled sink: fill the buffer until it refuses
        echo(1'b1);
        stall = 1'b1;
        drops = 0;
        for (i = 0; i < 6; i++) begin
            @(negedge core_clk_i);
            rx_valid_i = 1'b1;
            rx_data_i = 8'h30 + 8'(i);
            exp_q.push_back(rx_data_i);
        end
        @(negedge core_clk_i);
        rx_valid_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        check(drops > 0, "no refusal");
        repeat (drops) exp_q.pop_back();
        stall = 1'b0;
        drain();
        print_verdict();
    end
endmodule : qse_status_echo_tb
`default_nettype wire
